// file: hdl/pmbpcm_cmd_map.sv
// Paged command map of a two-channel power manager, fed by a decoded serial command stream.
// Assumes the serial layer hands over one command per strobe and handles addressing and block framing.
// Notes on behaviour
// - Byte page selector at 0x00, unpaged, reset 0x00, steers paged commands.
// - Page 0xFF writes the masked-in channels, only fault clear, operation, on/off config.
// - Paged read with page 0xFF gives undefined data and a fault.
// - Paged write without global support under page 0xFF dropped with a fault.
// - Write protection level byte at 0x10, unpaged, default 0x00.
// - Bus address base byte at 0xE6, unpaged, default 0x5C.
// - Global page channel mask byte at 0xE4, unpaged, default 0x03.
// - Alternate host command word at 0xC8, unpaged, read and write.
// - Alternate host data words at 0xC9 and 0xCA, one per extra host.
// - Send byte 0xEC reinitialises the fault log area and drops its lock.
// - Block reads at 0xEE stream fault log bytes in order.
// - Read-only shared status byte at 0xEF.
// - Paged current gain tempco word at 0xF6, default 0x0000.
// - Unpaged retry limit byte at 0xF7, default 0x07.
// - Paged diode factor word at 0xF8, weight two to minus fourteen, default 0x4000.
// - Paged linear11 temperature offset word at 0xF9, default 0x8000.
// - Paged read-only current sense voltage magnitude at 0xFA.
// - Read-only minimum marks for output voltage, input voltage, temperature.
// - Linear11 holds a signed 5-bit exponent and signed 11-bit mantissa.
// - Linear16 is an unsigned mantissa with a fixed exponent.
// - Page 0x00 is channel zero, 0x01 channel one, 0xFF global, others reserved.
// - Mask bit 0 and bit 1 let each channel answer global accesses.
`timescale 1ns/100ps
`default_nettype none

module pmbpcm_cmd_map
	import pmbpcm_pkg::*;
#(
	parameter logic [7:0] OPERATION_CODE    = 8'h01,
	parameter logic [7:0] ON_OFF_CFG_CODE   = 8'h02,
	parameter logic [7:0] CLEAR_FAULTS_CODE = 8'h03
)
(
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic                       cmd_valid,
	input  wire pmbpcm_kind_type            cmd_kind,
	input  wire logic [7:0]                 cmd_code,
	input  wire logic [15:0]                cmd_data,
	output var  logic                       rsp_valid_q,
	output var  logic [15:0]                rsp_data_q,
	output var  logic                       rsp_hit_q,
	output var  logic                       cml_fault_q,
	output var  logic [1:0]                 chan_wr_q,
	output var  logic [7:0]                 chan_wr_code_q,
	output var  logic [15:0]                chan_wr_data_q,
	output var  logic                       fault_log_clear_q,
	input  wire logic                       fault_log_lock_set,
	input  wire logic                       log_wr_en,
	input  wire logic [`PMBPCM_LOG_AW-1:0]  log_wr_addr,
	input  wire logic [7:0]                 log_wr_data,
	input  wire logic [7:0]                 shared_status_in,
	input  wire pmbpcm_chan_word_type       sense_voltage_in,
	input  wire logic [1:0]                 vout_sample_valid,
	input  wire pmbpcm_chan_word_type       vout_sample,
	input  wire logic                       vin_sample_valid,
	input  wire logic [15:0]                vin_sample,
	input  wire logic [1:0]                 temp_sample_valid,
	input  wire pmbpcm_chan_word_type       temp_sample,
	output var  logic [7:0]                 page_select_q,
	output var  logic [7:0]                 write_protect_level_q,
	output var  logic [1:0]                 global_page_channel_mask_q,
	output var  logic [6:0]                 bus_address_base_q,
	output var  logic [7:0]                 retry_limit_q,
	output var  logic [15:0]                alt_host_command_word_q,
	output var  logic [15:0]                alt_host0_data_word_q,
	output var  logic [15:0]                alt_host1_data_word_q,
	output var  pmbpcm_chan_word_type       current_gain_tempco_q,
	output var  pmbpcm_chan_word_type       ext_temp_gain_q,
	output var  pmbpcm_chan_word_type       ext_temp_offset_q
);

	// Commands held per channel inside this block or taken per channel from the core.
	function automatic logic is_paged(input logic [7:0] code);
		return code == `PMBPCM_CMD_GAIN_TC || code == `PMBPCM_CMD_TEMP_GAIN
			|| code == `PMBPCM_CMD_TEMP_OFFSET || code == `PMBPCM_CMD_SENSE_V
			|| code == `PMBPCM_CMD_VOUT_LOW || code == `PMBPCM_CMD_TEMP_LOW;
	endfunction

	// The only commands that accept the global page.
	function automatic logic is_global(input logic [7:0] code);
		return code == CLEAR_FAULTS_CODE || code == OPERATION_CODE || code == ON_OFF_CFG_CODE;
	endfunction

	logic                       wr_req;
	logic                       rd_req;
	logic                       send_req;
	logic                       page_global;
	logic                       page_chan;
	logic                       ch_sel;
	logic                       paged_wr_ok;
	logic                       log_locked_q;
	logic [`PMBPCM_LOG_AW-1:0]  log_ptr_q;
	logic [7:0]                 log_rd_data_q;
	logic                       log_rd;
	logic [15:0]                rd_word;
	logic                       rd_hit;
	logic                       fault_d;
	logic                       st1_valid_q;
	logic                       st1_hit_q;
	logic                       st1_log_q;
	logic [15:0]                st1_word_q;
	pmbpcm_chan_word_type       vout_low;
	pmbpcm_chan_word_type       temp_low;
	logic [15:0]                vin_low;

	// Request qualifiers and page decode.
	assign wr_req      = cmd_valid && cmd_kind == PMBPCM_KIND_WRITE;
	assign rd_req      = cmd_valid && cmd_kind == PMBPCM_KIND_READ;
	assign send_req    = cmd_valid && cmd_kind == PMBPCM_KIND_SEND;
	assign page_global = page_select_q == `PMBPCM_PAGE_GLOBAL;
	assign page_chan   = page_select_q == `PMBPCM_PAGE_CH0 || page_select_q == `PMBPCM_PAGE_CH1;
	assign ch_sel      = page_select_q == `PMBPCM_PAGE_CH1;
	assign paged_wr_ok = wr_req && page_chan;

	// Page selector; it is never paged itself.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			page_select_q <= `PMBPCM_RST_PAGE;
		else if (wr_req && cmd_code == `PMBPCM_CMD_PAGE)
			page_select_q <= cmd_data[7:0];
	end

	// Unpaged configuration bytes.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			write_protect_level_q      <= `PMBPCM_RST_WRITE_PROT;
			global_page_channel_mask_q <= `PMBPCM_RST_PAGE_MASK;
			bus_address_base_q         <= `PMBPCM_RST_ADDR_BASE;
			retry_limit_q              <= `PMBPCM_RST_RETRY;
		end
		else if (wr_req)
		begin
			if (cmd_code == `PMBPCM_CMD_WRITE_PROT)
				write_protect_level_q <= cmd_data[7:0];
			else if (cmd_code == `PMBPCM_CMD_PAGE_MASK)
				global_page_channel_mask_q <= cmd_data[1:0];
			else if (cmd_code == `PMBPCM_CMD_ADDR_BASE)
				bus_address_base_q <= cmd_data[6:0];
			else if (cmd_code == `PMBPCM_CMD_RETRY)
				retry_limit_q <= cmd_data[7:0];
		end
	end

	// Alternate host command and data words, shared by all pages.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			alt_host_command_word_q <= `PMBPCM_RST_WORD;
			alt_host0_data_word_q   <= `PMBPCM_RST_WORD;
			alt_host1_data_word_q   <= `PMBPCM_RST_WORD;
		end
		else if (wr_req)
		begin
			if (cmd_code == `PMBPCM_CMD_ALT_CMD)
				alt_host_command_word_q <= cmd_data;
			else if (cmd_code == `PMBPCM_CMD_ALT_DATA0)
				alt_host0_data_word_q <= cmd_data;
			else if (cmd_code == `PMBPCM_CMD_ALT_DATA1)
				alt_host1_data_word_q <= cmd_data;
		end
	end

	// Per-channel calibration words; only a real channel page reaches them.
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		logic hit_ch;

		assign hit_ch = paged_wr_ok && ch_sel == ch[0];

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
			begin
				current_gain_tempco_q[ch] <= `PMBPCM_RST_GAIN_TC;
				ext_temp_gain_q[ch]       <= `PMBPCM_RST_TEMP_GAIN;
				ext_temp_offset_q[ch]     <= `PMBPCM_RST_TEMP_OFFSET;
			end
			else if (hit_ch)
			begin
				if (cmd_code == `PMBPCM_CMD_GAIN_TC)
					current_gain_tempco_q[ch] <= cmd_data;
				else if (cmd_code == `PMBPCM_CMD_TEMP_GAIN)
					ext_temp_gain_q[ch] <= cmd_data;
				else if (cmd_code == `PMBPCM_CMD_TEMP_OFFSET)
					ext_temp_offset_q[ch] <= cmd_data;
			end
		end

		// Minimum marks of output voltage (unsigned linear16) and temperature (linear11).
		pmbpcm_low_mark #(.IS_L11(1'b0)) u_vout_low
		(
			.clk          (clk),
			.rstn         (rstn),
			.sample_valid (vout_sample_valid[ch]),
			.sample       (vout_sample[ch]),
			.mark_q       (vout_low[ch])
		);

		pmbpcm_low_mark #(.IS_L11(1'b1)) u_temp_low
		(
			.clk          (clk),
			.rstn         (rstn),
			.sample_valid (temp_sample_valid[ch]),
			.sample       (temp_sample[ch]),
			.mark_q       (temp_low[ch])
		);
	end

	// Input voltage minimum is shared by both pages.
	pmbpcm_low_mark #(.IS_L11(1'b1)) u_vin_low
	(
		.clk          (clk),
		.rstn         (rstn),
		.sample_valid (vin_sample_valid),
		.sample       (vin_sample),
		.mark_q       (vin_low)
	);

	// Global-capable commands go to the selected channel, or to masked-in channels on page 0xFF.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			chan_wr_q      <= 2'b00;
			chan_wr_code_q <= `PMBPCM_CMD_PAGE;
			chan_wr_data_q <= `PMBPCM_RST_WORD;
		end
		else
		begin
			chan_wr_q <= 2'b00;
			if ((wr_req || send_req) && is_global(cmd_code))
			begin
				chan_wr_code_q <= cmd_code;
				chan_wr_data_q <= cmd_data;
				if (page_global)
					chan_wr_q <= global_page_channel_mask_q;
				else if (page_chan)
					chan_wr_q <= ch_sel ? 2'b10 : 2'b01;
			end
		end
	end

	// Fault log lock and clear; a lock arriving with the clear still wins.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			log_locked_q      <= 1'b0;
			fault_log_clear_q <= 1'b0;
		end
		else
		begin
			fault_log_clear_q <= send_req && cmd_code == `PMBPCM_CMD_LOG_CLEAR;
			if (fault_log_lock_set)
				log_locked_q <= 1'b1;
			else if (send_req && cmd_code == `PMBPCM_CMD_LOG_CLEAR)
				log_locked_q <= 1'b0;
		end
	end

	// Read pointer of the log stream; each read takes the next byte, the clear rewinds it.
	assign log_rd = rd_req && cmd_code == `PMBPCM_CMD_LOG_STREAM;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			log_ptr_q <= '0;
		else if (send_req && cmd_code == `PMBPCM_CMD_LOG_CLEAR)
			log_ptr_q <= '0;
		else if (log_rd)
			log_ptr_q <= log_ptr_q + 1'b1;
	end

	pmbpcm_log_ram u_log_ram
	(
		.clk       (clk),
		.wr_en     (log_wr_en),
		.wr_addr   (log_wr_addr),
		.wr_data   (log_wr_data),
		.rd_en     (log_rd),
		.rd_addr   (log_ptr_q),
		.rd_data_q (log_rd_data_q)
	);

	// Read decode; paged codes take the selected channel's value, page 0xFF gives undefined data.
	always_comb
	begin
		rd_word = `PMBPCM_RST_WORD;
		rd_hit  = 1'b1;
		if (is_paged(cmd_code) && !page_chan)
			rd_word = `PMBPCM_UNDEF_WORD;
		else if (cmd_code == `PMBPCM_CMD_PAGE)
			rd_word = {8'h00, page_select_q};
		else if (cmd_code == `PMBPCM_CMD_WRITE_PROT)
			rd_word = {8'h00, write_protect_level_q};
		else if (cmd_code == `PMBPCM_CMD_ALT_CMD)
			rd_word = alt_host_command_word_q;
		else if (cmd_code == `PMBPCM_CMD_ALT_DATA0)
			rd_word = alt_host0_data_word_q;
		else if (cmd_code == `PMBPCM_CMD_ALT_DATA1)
			rd_word = alt_host1_data_word_q;
		else if (cmd_code == `PMBPCM_CMD_PAGE_MASK)
			rd_word = {14'h0000, global_page_channel_mask_q};
		else if (cmd_code == `PMBPCM_CMD_ADDR_BASE)
			rd_word = {9'h000, bus_address_base_q};
		else if (cmd_code == `PMBPCM_CMD_LOG_STATE)
			rd_word = {15'h0000, log_locked_q};
		else if (cmd_code == `PMBPCM_CMD_LOG_STREAM)
			rd_word = `PMBPCM_RST_WORD;
		else if (cmd_code == `PMBPCM_CMD_SHARED_STAT)
			rd_word = {8'h00, shared_status_in};
		else if (cmd_code == `PMBPCM_CMD_GAIN_TC)
			rd_word = current_gain_tempco_q[ch_sel];
		else if (cmd_code == `PMBPCM_CMD_RETRY)
			rd_word = {8'h00, retry_limit_q};
		else if (cmd_code == `PMBPCM_CMD_TEMP_GAIN)
			rd_word = ext_temp_gain_q[ch_sel];
		else if (cmd_code == `PMBPCM_CMD_TEMP_OFFSET)
			rd_word = ext_temp_offset_q[ch_sel];
		else if (cmd_code == `PMBPCM_CMD_SENSE_V)
			rd_word = sense_voltage_in[ch_sel];
		else if (cmd_code == `PMBPCM_CMD_VOUT_LOW)
			rd_word = vout_low[ch_sel];
		else if (cmd_code == `PMBPCM_CMD_VIN_LOW)
			rd_word = vin_low;
		else if (cmd_code == `PMBPCM_CMD_TEMP_LOW)
			rd_word = temp_low[ch_sel];
		else
			rd_hit = 1'b0;
	end

	// A paged access on page 0xFF or a reserved page is refused and flagged.
	always_comb
	begin
		fault_d = 1'b0;
		if (!page_chan && is_paged(cmd_code) && (rd_req || wr_req))
			fault_d = 1'b1;
	end

	// First answer stage, aligned with the log memory read.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st1_valid_q <= 1'b0;
			st1_hit_q   <= 1'b0;
			st1_log_q   <= 1'b0;
			st1_word_q  <= `PMBPCM_RST_WORD;
			cml_fault_q <= 1'b0;
		end
		else
		begin
			st1_valid_q <= rd_req;
			st1_hit_q   <= rd_hit;
			st1_log_q   <= log_rd;
			st1_word_q  <= rd_word;
			cml_fault_q <= fault_d;
		end
	end

	// Second answer stage drives the registered read answer.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rsp_valid_q <= 1'b0;
			rsp_hit_q   <= 1'b0;
			rsp_data_q  <= `PMBPCM_RST_WORD;
		end
		else
		begin
			rsp_valid_q <= st1_valid_q;
			rsp_hit_q   <= st1_valid_q && st1_hit_q;
			if (st1_valid_q)
				rsp_data_q <= st1_log_q ? {8'h00, log_rd_data_q} : st1_word_q;
		end
	end

endmodule

`default_nettype wire

// file: hdl/pmbpcm_consts.svh
// Named constants of the paged command map: command codes, reset values and field positions.
// Assumes it is included by its bare name from the package, which the design modules import.
`ifndef PMBPCM_CONSTS_SVH
`define PMBPCM_CONSTS_SVH

`define PMBPCM_CMD_PAGE          8'h00
`define PMBPCM_CMD_WRITE_PROT    8'h10
`define PMBPCM_CMD_ALT_CMD       8'hC8
`define PMBPCM_CMD_ALT_DATA0     8'hC9
`define PMBPCM_CMD_ALT_DATA1     8'hCA
`define PMBPCM_CMD_PAGE_MASK     8'hE4
`define PMBPCM_CMD_ADDR_BASE     8'hE6
`define PMBPCM_CMD_LOG_CLEAR     8'hEC
`define PMBPCM_CMD_LOG_STATE     8'hED
`define PMBPCM_CMD_LOG_STREAM    8'hEE
`define PMBPCM_CMD_SHARED_STAT   8'hEF
`define PMBPCM_CMD_GAIN_TC       8'hF6
`define PMBPCM_CMD_RETRY         8'hF7
`define PMBPCM_CMD_TEMP_GAIN     8'hF8
`define PMBPCM_CMD_TEMP_OFFSET   8'hF9
`define PMBPCM_CMD_SENSE_V       8'hFA
`define PMBPCM_CMD_VOUT_LOW      8'hFB
`define PMBPCM_CMD_VIN_LOW       8'hFC
`define PMBPCM_CMD_TEMP_LOW      8'hFD

`define PMBPCM_PAGE_CH0          8'h00
`define PMBPCM_PAGE_CH1          8'h01
`define PMBPCM_PAGE_GLOBAL       8'hFF

`define PMBPCM_RST_PAGE          8'h00
`define PMBPCM_RST_WRITE_PROT    8'h00
`define PMBPCM_RST_PAGE_MASK     2'h3
`define PMBPCM_RST_ADDR_BASE     7'h5C
`define PMBPCM_RST_GAIN_TC       16'h0000
`define PMBPCM_RST_RETRY         8'h07
`define PMBPCM_RST_TEMP_GAIN     16'h4000
`define PMBPCM_RST_TEMP_OFFSET   16'h8000
`define PMBPCM_RST_WORD          16'h0000

`define PMBPCM_UNDEF_WORD        16'hFFFF
`define PMBPCM_LOG_DEPTH         256
`define PMBPCM_LOG_AW            8
`define PMBPCM_L11_EXP_MSB       15
`define PMBPCM_L11_EXP_LSB       11
`define PMBPCM_L11_MAN_MSB       10
`define PMBPCM_L11_BIAS          6'h10

`endif

// file: hdl/pmbpcm_pkg.sv
// Types shared by the paged command map modules.
// Assumes the constants header sits beside it.
`include "pmbpcm_consts.svh"

package pmbpcm_pkg;

	// Kind of transaction handed over by the serial layer.
	typedef enum logic [1:0]
	{
		PMBPCM_KIND_WRITE,
		PMBPCM_KIND_READ,
		PMBPCM_KIND_SEND
	} pmbpcm_kind_type;

	// One 16-bit word per channel.
	typedef logic [1:0][15:0] pmbpcm_chan_word_type;

endpackage

// file: hdl/pmbpcm_log_ram.sv
// Fault log byte store with one write port and one registered read port.
// Assumes one clock; the read data appear on the edge after the read enable.
`timescale 1ns/100ps
`default_nettype none

module pmbpcm_log_ram
	import pmbpcm_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       wr_en,
	input  wire logic [`PMBPCM_LOG_AW-1:0]  wr_addr,
	input  wire logic [7:0]                 wr_data,
	input  wire logic                       rd_en,
	input  wire logic [`PMBPCM_LOG_AW-1:0]  rd_addr,
	output var  logic [7:0]                 rd_data_q
);

	logic [7:0] mem [`PMBPCM_LOG_DEPTH];

	// Storage array; no reset so it maps onto a memory macro.
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Registered read port.
	always_ff @(posedge clk)
	begin
		if (rd_en)
			rd_data_q <= mem[rd_addr];
	end

endmodule

`default_nettype wire

// file: hdl/pmbpcm_low_mark.sv
// Minimum tracker for one telemetry channel in linear11 or unsigned linear16 form.
// Assumes samples arrive as one-cycle strobes from the measurement core.
`timescale 1ns/100ps
`default_nettype none

module pmbpcm_low_mark
	import pmbpcm_pkg::*;
#(
	parameter bit IS_L11 = 1'b1
)
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	output var  logic [15:0] mark_q
);

	logic seen_q;

	// Maps a word to a signed key that orders by real value; linear11 is mantissa times two to the exponent.
	function automatic logic signed [47:0] value_key(input logic [15:0] w);
		logic signed [47:0] man;
		logic        [5:0]  shamt;
		man   = 48'sh0;
		shamt = 6'h00;
		if (IS_L11)
		begin
			man   = 48'(signed'(w[`PMBPCM_L11_MAN_MSB:0]));
			shamt = 6'(signed'(w[`PMBPCM_L11_EXP_MSB:`PMBPCM_L11_EXP_LSB])) + `PMBPCM_L11_BIAS;
			return man <<< shamt;
		end
		return signed'({32'h0000_0000, w});
	endfunction

	// The first sample after reset seeds the mark; later ones only lower it.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			seen_q <= 1'b0;
			mark_q <= `PMBPCM_RST_WORD;
		end
		else if (sample_valid && (!seen_q || value_key(sample) < value_key(mark_q)))
		begin
			seen_q <= 1'b1;
			mark_q <= sample;
		end
	end

endmodule

`default_nettype wire

// file: tb/pmbpcm_cmd_map_checker.sv
// Concurrent checks on the ports of the paged command map.
// Assumes one clock domain and the asynchronous active-low reset of the map.
`timescale 1ns/100ps
`default_nettype none

module pmbpcm_cmd_map_checker
	import pmbpcm_pkg::*;
(
	input wire logic            clk,
	input wire logic            rstn,
	input wire logic            cmd_valid,
	input wire pmbpcm_kind_type cmd_kind,
	input wire logic [7:0]      cmd_code,
	input wire logic [15:0]     cmd_data,
	input wire logic            rsp_valid_q,
	input wire logic [15:0]     rsp_data_q,
	input wire logic            cml_fault_q,
	input wire logic [1:0]      chan_wr_q,
	input wire logic            fault_log_clear_q,
	input wire logic [7:0]      page_select_q,
	input wire logic [1:0]      global_page_channel_mask_q,
	input wire logic [7:0]      retry_limit_q
);
	logic wr;
	logic rd;
	logic paged;
	logic bad_page;
	logic glob;
	logic fault_cause;

	// Decoded views of the command on the input lines.
	assign wr = cmd_valid && cmd_kind == PMBPCM_KIND_WRITE;
	assign rd = cmd_valid && cmd_kind == PMBPCM_KIND_READ;
	assign paged = cmd_code inside {8'hF6, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFD};
	assign bad_page = !(page_select_q inside {8'h00, 8'h01});
	assign glob = cmd_code inside {8'h01, 8'h02, 8'h03};
	assign fault_cause = cmd_valid && paged && bad_page;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	page_write_a: assert property (wr && cmd_code == 8'h00 |=> page_select_q == $past(cmd_data[7:0]))
		else $error("page byte not taken");
	bad_read_a: assert property (rd && paged && bad_page |=>
		cml_fault_q ##1 rsp_valid_q && rsp_data_q == 16'hFFFF)
		else $error("bad page read not faulted");
	bad_write_a: assert property (wr && paged && bad_page |=> cml_fault_q && chan_wr_q == 2'b00)
		else $error("bad page write not refused");
	global_fwd_a: assert property (wr && glob && page_select_q == 8'hFF |=>
		chan_wr_q == $past(global_page_channel_mask_q))
		else $error("global write misrouted");
	chan_fwd_a: assert property (wr && glob && !bad_page |=>
		chan_wr_q == (2'b01 << $past(page_select_q[0])))
		else $error("channel write misrouted");
	good_quiet_a: assert property (cmd_valid && !bad_page |=> !cml_fault_q)
		else $error("fault on a valid page");
	fault_cause_a: assert property (cml_fault_q |-> $past(fault_cause))
		else $error("fault raised without a cause");
	log_clear_a: assert property (cmd_valid && cmd_kind == PMBPCM_KIND_SEND && cmd_code == 8'hEC |=>
		fault_log_clear_q)
		else $error("log clear not pulsed");
	retry_read_a: assert property (rd && cmd_code == 8'hF7 |->
		##2 rsp_valid_q && rsp_data_q == {8'h00, $past(retry_limit_q, 2)})
		else $error("retry limit read wrong");
endmodule

bind pmbpcm_cmd_map pmbpcm_cmd_map_checker u_chk (.clk, .rstn, .cmd_valid, .cmd_kind, .cmd_code, .cmd_data,
	.rsp_valid_q, .rsp_data_q, .cml_fault_q, .chan_wr_q, .fault_log_clear_q, .page_select_q,
	.global_page_channel_mask_q, .retry_limit_q);

`default_nettype wire

// file: tb/pmbpcm_host_model.sv
// Host model that issues decoded command strobes and notes what answers them.
// Assumes its tasks are called one at a time by the bench.
`timescale 1ns/100ps
`default_nettype none

module pmbpcm_host_model
	import pmbpcm_pkg::*;
(
	input  wire logic            clk,
	output var  logic            cmd_valid,
	output var  pmbpcm_kind_type cmd_kind,
	output var  logic [7:0]      cmd_code,
	output var  logic [15:0]     cmd_data,
	input  wire logic            rsp_valid_q,
	input  wire logic [15:0]     rsp_data_q,
	input  wire logic            cml_fault_q,
	input  wire logic [1:0]      chan_wr_q
);
	logic        last_fault;
	logic [1:0]  last_fwd;
	logic [15:0] last_data;

	// Idle bus at time zero.
	initial
	begin
		cmd_valid = 1'b0;
		cmd_kind = PMBPCM_KIND_READ;
		cmd_code = 8'h00;
		cmd_data = 16'h0000;
	end

	// One strobe; flags are noted a cycle later, read data two cycles later.
	task automatic issue(input pmbpcm_kind_type kind, input logic [7:0] code, input logic [15:0] data);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_kind <= kind;
		cmd_code <= code;
		cmd_data <= data;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_data <= ~data; // Released data changes so stale values are never trusted.
		#1;
		last_fault = cml_fault_q;
		last_fwd = chan_wr_q;
		@(posedge clk);
		#1;
		last_data = rsp_valid_q ? rsp_data_q : 16'hXXXX;
	endtask

	// Channel selection always precedes per-channel configuration.
	task automatic set_page(input logic [7:0] page);
		issue(PMBPCM_KIND_WRITE, 8'h00, {8'h00, page});
	endtask
endmodule

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the paged command map.
// Assumes the host model drives the command port and this module drives the core-side inputs.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import pmbpcm_pkg::*;

	logic                 clk = 1'b0;
	logic                 rstn = 1'b0;
	logic                 cmd_valid;
	pmbpcm_kind_type      cmd_kind;
	logic [7:0]           cmd_code;
	logic [15:0]          cmd_data;
	logic                 rsp_valid_q;
	logic [15:0]          rsp_data_q;
	logic                 cml_fault_q;
	logic [1:0]           chan_wr_q;
	logic                 lock_set = 1'b0;
	logic                 log_we = 1'b0;
	logic [7:0]           log_addr = 8'h00;
	logic [7:0]           log_data = 8'h00;
	logic [7:0]           status;
	pmbpcm_chan_word_type sense = {16'h0BB0, 16'h0AA0};
	logic [1:0]           vout_v = 2'b00;
	pmbpcm_chan_word_type vout = '0;
	logic                 vin_v = 1'b0;
	logic [15:0]          vin = 16'h0000;
	logic [1:0]           temp_v = 2'b00;
	pmbpcm_chan_word_type temp = '0;
	int                   bad_count = 0;
	int                   n_checks = 0;
	logic [7:0]           rc [9] = '{8'h00, 8'h10, 8'hE4, 8'hE6, 8'hF7, 8'hF6, 8'hF8, 8'hF9, 8'hC8};
	logic [15:0]          rv [9] = '{16'h0000, 16'h0000, 16'h0003, 16'h005C, 16'h0007, 16'h0000, 16'h4000, 16'h8000, 16'h0000};
	logic [7:0]           wc [7] = '{8'h10, 8'hC8, 8'hC9, 8'hCA, 8'hF7, 8'hE6, 8'hE4};
	logic [15:0]          wd [7] = '{16'h0040, 16'hA55A, 16'h1234, 16'h4321, 16'h0003, 16'h00FF, 16'h00FF};
	logic [15:0]          we [7] = '{16'h0040, 16'hA55A, 16'h1234, 16'h4321, 16'h0003, 16'h007F, 16'h0003};
	logic [7:0]           gp [2] = '{8'hFF, 8'h02};
	logic [47:0]          smp [3] = '{48'h1300_D280_E0A0, 48'h1200_D680_E0C0, 48'h1400_D380_E0B0};

	// Clock at 100 MHz.
	always #5 clk = ~clk;

	pmbpcm_host_model u_host (.clk, .cmd_valid, .cmd_kind, .cmd_code, .cmd_data, .rsp_valid_q, .rsp_data_q,
		.cml_fault_q, .chan_wr_q);

	pmbpcm_cmd_map u_dut (.clk, .rstn, .cmd_valid, .cmd_kind, .cmd_code, .cmd_data, .rsp_valid_q, .rsp_data_q,
		.rsp_hit_q(), .cml_fault_q, .chan_wr_q, .chan_wr_code_q(), .chan_wr_data_q(),
		.fault_log_clear_q(), .fault_log_lock_set(lock_set), .log_wr_en(log_we), .log_wr_addr(log_addr),
		.log_wr_data(log_data), .shared_status_in(status), .sense_voltage_in(sense), .vout_sample_valid(vout_v),
		.vout_sample(vout), .vin_sample_valid(vin_v), .vin_sample(vin), .temp_sample_valid(temp_v),
		.temp_sample(temp), .page_select_q(), .write_protect_level_q(), .global_page_channel_mask_q(),
		.bus_address_base_q(), .retry_limit_q(), .alt_host_command_word_q(), .alt_host0_data_word_q(),
		.alt_host1_data_word_q(), .current_gain_tempco_q(), .ext_temp_gain_q(), .ext_temp_offset_q());

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input string what, input logic [7:0] code, input logic [15:0] exp);
		u_host.issue(PMBPCM_KIND_READ, code, 16'h0000);
		check(what, u_host.last_data, exp);
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		u_host.issue(PMBPCM_KIND_WRITE, code, data);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the sequence needs.
	initial
	begin
		#200us;
		bad_count++;
		summarize();
	end

	// Main sequence.
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rd("reset value", rc[i], rv[i]);
		for (int i = 0; i < 7; i++)
			wr(wc[i], wd[i]);
		for (int i = 0; i < 7; i++)
			rd("unpaged readback", wc[i], we[i]);
		$display("unpaged registers done");
		u_host.set_page(8'h00);
		wr(8'hF6, 16'h1234);
		rd("sense channel 0", 8'hFA, 16'h0AA0);
		u_host.set_page(8'h01);
		wr(8'hF6, 16'hABCD);
		rd("tempco channel 1", 8'hF6, 16'hABCD);
		rd("sense channel 1", 8'hFA, 16'h0BB0);
		u_host.set_page(8'h00);
		rd("tempco channel 0", 8'hF6, 16'h1234);
		check("fault on valid page", 16'(u_host.last_fault), 16'h0000);
		$display("paged registers done");
		for (int i = 0; i < 2; i++)
		begin
			u_host.set_page(gp[i]);
			rd("paged read on global page", 8'hF6, 16'hFFFF);
			check("read fault", 16'(u_host.last_fault), 16'h0001);
			wr(8'hF8, 16'h1111);
			check("write fault", 16'(u_host.last_fault), 16'h0001);
			wr(8'h01, 16'h0080);
			check("global forward", 16'(u_host.last_fwd), (i == 0) ? 16'h0003 : 16'h0000);
		end
		wr(8'hE4, 16'h0002);
		u_host.set_page(8'hFF);
		wr(8'h03, 16'h0000);
		check("masked forward", 16'(u_host.last_fwd), 16'h0002);
		u_host.set_page(8'h01);
		wr(8'h02, 16'h0000);
		check("channel 1 forward", 16'(u_host.last_fwd), 16'h0002);
		rd("dropped global write", 8'hF8, 16'h4000);
		$display("global page done");
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk);
			log_we <= i < 3;
			lock_set <= i == 3;
			log_addr <= 8'(i);
			log_data <= 8'hA0 + 8'(i);
			status <= 8'h5A ^ 8'(i);
		end
		rd("log byte 0", 8'hEE, 16'h00A0);
		rd("log byte 1", 8'hEE, 16'h00A1);
		rd("log locked", 8'hED, 16'h0001);
		u_host.issue(PMBPCM_KIND_SEND, 8'hEC, 16'h0000);
		rd("log unlocked", 8'hED, 16'h0000);
		rd("log rewound", 8'hEE, 16'h00A0);
		wr(8'hEF, 16'h00FF);
		rd("shared status", 8'hEF, 16'h005E);
		$display("log and status done");
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			{vout_v[0], vin_v, temp_v[1]} <= {3{i < 3}};
			{vout[0], vin, temp[1]} <= smp[i % 3];
		end
		u_host.set_page(8'h00);
		rd("vout low mark", 8'hFB, 16'h1200);
		rd("vin low mark", 8'hFC, 16'hD680);
		u_host.set_page(8'h01);
		rd("temp low mark", 8'hFD, 16'hE0A0);
		$display("low marks done");
		summarize();
	end
endmodule

`default_nettype wire
